/* File: interrupt_source_map_pkg.sv */
// Constants, codes and types shared by the interrupt source map design files
package interrupt_source_map_pkg;
    localparam int NUM_IRQ = 32;
    localparam int NUM_EXC = 35;
    localparam int IDX_NMI = 32;
    localparam int IDX_SVC = 33;
    localparam int IDX_PENDED_SVC = 34;
    localparam int IRQ_SPI0 = 0;
    localparam int IRQ_SPI1 = 1;
    localparam int IRQ_USART0 = 3;
    localparam int IRQ_USART1 = 4;
    localparam int IRQ_USART2 = 5;
    localparam int IRQ_TWO_WIRE = 8;
    localparam int IRQ_STATE_TIMER = 9;
    localparam int IRQ_MULTIRATE = 10;
    localparam int IRQ_COMPARATOR = 11;
    localparam int IRQ_WATCHDOG = 12;
    localparam int IRQ_BROWNOUT = 13;
    localparam int IRQ_WAKEUP = 15;
    localparam int IRQ_PIN_BASE = 24;
    localparam int SERIAL_FLAG_W = 8;
    localparam int TWO_WIRE_FLAG_W = 8;
    localparam int TIMER_EVENT_W = 8;
    localparam int MULTIRATE_CH = 4;
    localparam int PIN_CH = 8;
    localparam logic [5:0] EXC_IRQ_BASE = 6'h10;
    localparam logic [5:0] EXC_NMI = 6'h02;
    localparam logic [5:0] EXC_SVC = 6'h0b;
    localparam logic [5:0] EXC_PENDED_SVC = 6'h0e;
    localparam logic [2:0] PRIO_NMI = 3'h0;
    localparam logic [2:0] PRIO_NONE = 3'h7;
    localparam logic [1:0] PRIO_RESET = 2'h0;
    localparam logic [31:0] VECTOR_BASE_RESET = 32'h00000000;
    localparam logic [31:0] VECTOR_BASE_MASK = 32'hffffff80;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ENTRY = 2'b10
    } entry_state_type;
endpackage

/* File: request_collector.sv */
// Gathers one peripheral's enabled source flags into one registered request line
`timescale 1ns/1ps
module request_collector #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] flags,
    input wire logic [W-1:0] enables,
    output logic req
);
    wire anyActive = |(flags & enables);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            req <= 1'b0;
        end else begin
            req <= anyActive;
        end
    end
endmodule

/* File: priority_picker.sv */
// Picks the most urgent candidate; on a tie the lowest index wins
`timescale 1ns/1ps
module priority_picker #(
    parameter int N = 35
) (
    input wire logic [N-1:0] cand,
    input wire logic [3*N-1:0] prio,
    output logic found,
    output logic [5:0] bestIdx,
    output logic [2:0] bestPrio
);
    always_comb begin
        found = 1'b0;
        bestIdx = 6'h00;
        bestPrio = interrupt_source_map_pkg::PRIO_NONE;
        for (int i = 0; i < N; i++) begin
            // Strictly-less keeps the earlier, lower-numbered one on a tie
            if (cand[i] && (prio[3*i +: 3] < bestPrio)) begin
                found = 1'b1;
                bestIdx = 6'(i);
                bestPrio = prio[3*i +: 3];
            end
        end
    end
endmodule

/* File: interrupt_source_map.sv */
// Interrupt source map: line collection, pending/active state, arbitration and entry hand-off
`timescale 1ns/1ps
module interrupt_source_map (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] spiFlags0,
    input wire logic [7:0] spiEnables0,
    input wire logic [7:0] spiFlags1,
    input wire logic [7:0] spiEnables1,
    input wire logic [7:0] usartFlags0,
    input wire logic [7:0] usartEnables0,
    input wire logic [7:0] usartFlags1,
    input wire logic [7:0] usartEnables1,
    input wire logic [7:0] usartFlags2,
    input wire logic [7:0] usartEnables2,
    input wire logic [7:0] twoWireFlags,
    input wire logic [7:0] twoWireEnables,
    input wire logic [7:0] timer_event_flags,
    input wire logic [7:0] timerEventEnables,
    input wire logic [3:0] multirateFlags,
    input wire logic comparator_edge_flag,
    input wire logic watchdog_warning_flag,
    input wire logic brownoutLevelFlag,
    input wire logic wakeup_alarm_flag,
    input wire logic [7:0] pin_event_status,
    input wire logic enableWrite,
    input wire logic [4:0] enableIndex,
    input wire logic enableValue,
    input wire logic prioWrite,
    input wire logic [5:0] prioIndex,
    input wire logic [1:0] prioValue,
    input wire logic pendSet,
    input wire logic pendClear,
    input wire logic [4:0] pendIndex,
    input wire logic svcRequest,
    input wire logic pendSvSet,
    input wire logic nmiSoftware,
    input wire logic nmiSourceEnable,
    input wire logic [4:0] nmiSourceIndex,
    input wire logic boostEnable,
    input wire logic [1:0] boostLevel,
    input wire logic vectorBaseWrite,
    input wire logic [31:0] vectorBaseData,
    input wire logic excAccept,
    input wire logic excEntryDone,
    input wire logic excReturn,
    output logic excRequest,
    output logic [5:0] excNumber,
    output logic [31:0] excVector,
    output logic lateArrival,
    output logic [2:0] runningPriority,
    output logic [31:0] pendingStatus,
    output logic [31:0] enableStatus,
    output logic [31:0] vector_base_reg
);
    localparam int NE = interrupt_source_map_pkg::NUM_EXC;
    localparam int NI = interrupt_source_map_pkg::NUM_IRQ;

    wire serial_periph0_req;
    wire serial_periph1_req;
    wire async_serial0_req;
    wire async_serial1_req;
    wire async_serial2_req;
    wire two_wire_req;
    wire state_timer_req;
    wire multirate_timer_req;
    wire [11:0] singleReq;
    wire [31:0] irqLines;

    request_collector #(.W(interrupt_source_map_pkg::SERIAL_FLAG_W)) u_spi0 (
        .clk(clk), .reset(reset), .flags(spiFlags0), .enables(spiEnables0), .req(serial_periph0_req));
    request_collector #(.W(interrupt_source_map_pkg::SERIAL_FLAG_W)) u_spi1 (
        .clk(clk), .reset(reset), .flags(spiFlags1), .enables(spiEnables1), .req(serial_periph1_req));
    request_collector #(.W(interrupt_source_map_pkg::SERIAL_FLAG_W)) u_usart0 (
        .clk(clk), .reset(reset), .flags(usartFlags0), .enables(usartEnables0), .req(async_serial0_req));
    request_collector #(.W(interrupt_source_map_pkg::SERIAL_FLAG_W)) u_usart1 (
        .clk(clk), .reset(reset), .flags(usartFlags1), .enables(usartEnables1), .req(async_serial1_req));
    request_collector #(.W(interrupt_source_map_pkg::SERIAL_FLAG_W)) u_usart2 (
        .clk(clk), .reset(reset), .flags(usartFlags2), .enables(usartEnables2), .req(async_serial2_req));
    request_collector #(.W(interrupt_source_map_pkg::TWO_WIRE_FLAG_W)) u_two_wire (
        .clk(clk), .reset(reset), .flags(twoWireFlags), .enables(twoWireEnables), .req(two_wire_req));
    request_collector #(.W(interrupt_source_map_pkg::TIMER_EVENT_W)) u_state_timer (
        .clk(clk), .reset(reset), .flags(timer_event_flags), .enables(timerEventEnables),
        .req(state_timer_req));
    // Global multi-rate line: every channel flag counts
    request_collector #(.W(interrupt_source_map_pkg::MULTIRATE_CH)) u_multirate (
        .clk(clk), .reset(reset), .flags(multirateFlags), .enables({4{1'b1}}),
        .req(multirate_timer_req));

    // Single-flag sources share the same one-cycle registration as the wide ones
    wire [11:0] singleFlags = {pin_event_status, wakeup_alarm_flag, brownoutLevelFlag,
                               watchdog_warning_flag, comparator_edge_flag};
    for (genvar s = 0; s < 12; s++) begin : g_single
        request_collector #(.W(1)) u_single (
            .clk(clk), .reset(reset), .flags(singleFlags[s]), .enables(1'b1), .req(singleReq[s]));
    end

    // Fixed number map; reserved numbers are constant zero
    assign irqLines[interrupt_source_map_pkg::IRQ_SPI0] = serial_periph0_req;
    assign irqLines[interrupt_source_map_pkg::IRQ_SPI1] = serial_periph1_req;
    assign irqLines[2] = 1'b0;
    assign irqLines[interrupt_source_map_pkg::IRQ_USART0] = async_serial0_req;
    assign irqLines[interrupt_source_map_pkg::IRQ_USART1] = async_serial1_req;
    assign irqLines[interrupt_source_map_pkg::IRQ_USART2] = async_serial2_req;
    assign irqLines[7:6] = 2'h0;
    assign irqLines[interrupt_source_map_pkg::IRQ_TWO_WIRE] = two_wire_req;
    assign irqLines[interrupt_source_map_pkg::IRQ_STATE_TIMER] = state_timer_req;
    assign irqLines[interrupt_source_map_pkg::IRQ_MULTIRATE] = multirate_timer_req;
    assign irqLines[interrupt_source_map_pkg::IRQ_COMPARATOR] = singleReq[0];
    assign irqLines[interrupt_source_map_pkg::IRQ_WATCHDOG] = singleReq[1];
    assign irqLines[interrupt_source_map_pkg::IRQ_BROWNOUT] = singleReq[2];
    assign irqLines[14] = 1'b0;
    assign irqLines[interrupt_source_map_pkg::IRQ_WAKEUP] = singleReq[3];
    assign irqLines[23:16] = 8'h00;
    assign irqLines[28:24] = singleReq[8:4];
    assign irqLines[31:29] = singleReq[11:9];

    logic [NE-1:0] pend;
    logic [NE-1:0] active;
    logic [2*NE-1:0] prioReg;
    interrupt_source_map_pkg::entry_state_type state;
    logic [5:0] presentedIdx;
    logic [2:0] presentedPrio;

    // Extended priority: 0 is the non-maskable slot, programmable level p becomes p+1
    wire [3*NE-1:0] extPrio;
    for (genvar e = 0; e < NE; e++) begin : g_prio
        if (e == interrupt_source_map_pkg::IDX_NMI) begin : g_nmi
            assign extPrio[3*e +: 3] = interrupt_source_map_pkg::PRIO_NMI;
        end else begin : g_prog
            assign extPrio[3*e +: 3] = 3'({1'b0, prioReg[2*e +: 2]} + 3'h1);
        end
    end

    wire runFound;
    wire [5:0] runIdx;
    wire [2:0] runPrio;
    priority_picker #(.N(NE)) u_running (
        .cand(active), .prio(extPrio), .found(runFound), .bestIdx(runIdx), .bestPrio(runPrio));

    wire [2:0] maskThresh = boostEnable ? 3'({1'b0, boostLevel} + 3'h1) : interrupt_source_map_pkg::PRIO_NONE;
    wire [NE-1:0] eligible;
    for (genvar e = 0; e < NE; e++) begin : g_elig
        // Only strictly more urgent than the running level may preempt
        assign eligible[e] = pend[e] && !active[e] && (extPrio[3*e +: 3] < runPrio) &&
                             (e == interrupt_source_map_pkg::IDX_NMI || extPrio[3*e +: 3] < maskThresh);
    end

    wire candFound;
    wire [5:0] candIdx;
    wire [2:0] candPrio;
    priority_picker #(.N(NE)) u_pending (
        .cand(eligible), .prio(extPrio), .found(candFound), .bestIdx(candIdx), .bestPrio(candPrio));

    wire inIdle = (state == interrupt_source_map_pkg::ST_IDLE);
    wire inEntry = (state == interrupt_source_map_pkg::ST_ENTRY);
    wire takeEntry = inIdle && excRequest && excAccept;
    wire entryCommit = inEntry && excEntryDone;
    wire lateSwitch = inEntry && !excEntryDone && candFound && (candPrio < presentedPrio);
    wire holdPresented = (inEntry && !lateSwitch) || takeEntry;

    // Pending: hardware and software sets win over a clear in the same cycle
    wire nmiLine = nmiSourceEnable && irqLines[nmiSourceIndex];
    wire [NE-1:0] setPend;
    wire [NE-1:0] clrPend;
    wire [NE-1:0] setAct;
    wire [NE-1:0] clrAct;
    for (genvar e = 0; e < NI; e++) begin : g_irq_pend
        assign setPend[e] = (irqLines[e] && enableStatus[e]) || (pendSet && pendIndex == 5'(e));
        assign clrPend[e] = pendClear && pendIndex == 5'(e);
    end
    assign setPend[interrupt_source_map_pkg::IDX_NMI] = nmiSoftware || nmiLine;
    assign setPend[interrupt_source_map_pkg::IDX_SVC] = svcRequest;
    assign setPend[interrupt_source_map_pkg::IDX_PENDED_SVC] = pendSvSet;
    assign clrPend[NE-1:NI] = 3'h0;
    for (genvar e = 0; e < NE; e++) begin : g_act
        assign setAct[e] = entryCommit && presentedIdx == 6'(e);
        assign clrAct[e] = excReturn && runFound && runIdx == 6'(e);
    end
    wire [NE-1:0] next_pend = (pend & ~(clrPend | setAct)) | setPend;
    wire [NE-1:0] next_active = (active & ~clrAct) | setAct;

    wire [5:0] next_presentedIdx = holdPresented ? presentedIdx : candIdx;
    wire [2:0] next_presentedPrio = holdPresented ? presentedPrio : candPrio;
    wire next_request = entryCommit ? 1'b0 : ((inEntry || takeEntry) ? 1'b1 : candFound);
    interrupt_source_map_pkg::entry_state_type next_state;
    always_comb begin
        case (state)
            interrupt_source_map_pkg::ST_IDLE: begin
                next_state = takeEntry ? interrupt_source_map_pkg::ST_ENTRY : interrupt_source_map_pkg::ST_IDLE;
            end
            interrupt_source_map_pkg::ST_ENTRY: begin
                next_state = entryCommit ? interrupt_source_map_pkg::ST_IDLE : interrupt_source_map_pkg::ST_ENTRY;
            end
            default: begin
                next_state = interrupt_source_map_pkg::ST_IDLE;
            end
        endcase
    end

    // Each index has its own vector slot, one word per exception number
    wire [5:0] next_number = (next_presentedIdx == 6'(interrupt_source_map_pkg::IDX_NMI)) ?
                             interrupt_source_map_pkg::EXC_NMI :
                             (next_presentedIdx == 6'(interrupt_source_map_pkg::IDX_SVC)) ?
                             interrupt_source_map_pkg::EXC_SVC :
                             (next_presentedIdx == 6'(interrupt_source_map_pkg::IDX_PENDED_SVC)) ?
                             interrupt_source_map_pkg::EXC_PENDED_SVC :
                             6'(next_presentedIdx + interrupt_source_map_pkg::EXC_IRQ_BASE);
    wire [31:0] next_base = vectorBaseWrite ? (vectorBaseData & interrupt_source_map_pkg::VECTOR_BASE_MASK)
                                            : vector_base_reg;
    wire [31:0] next_vector = next_base + {24'h000000, next_number, 2'b00};

    wire [1:0] prioFill = prioValue;
    wire prioHit = prioWrite && prioIndex != 6'(interrupt_source_map_pkg::IDX_NMI) && prioIndex < 6'(NE);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pend <= '0;
            active <= '0;
            state <= interrupt_source_map_pkg::ST_IDLE;
            presentedIdx <= 6'h00;
            presentedPrio <= interrupt_source_map_pkg::PRIO_NONE;
        end else begin
            pend <= next_pend;
            active <= next_active;
            state <= next_state;
            presentedIdx <= next_presentedIdx;
            presentedPrio <= next_presentedPrio;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prioReg <= {NE{interrupt_source_map_pkg::PRIO_RESET}};
            enableStatus <= 32'h00000000;
        end else begin
            if (prioHit) begin
                prioReg[2*prioIndex +: 2] <= prioFill;
            end
            if (enableWrite) begin
                enableStatus[enableIndex] <= enableValue;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            vector_base_reg <= interrupt_source_map_pkg::VECTOR_BASE_RESET;
            excRequest <= 1'b0;
            excNumber <= 6'h00;
            excVector <= 32'h00000000;
            lateArrival <= 1'b0;
            runningPriority <= interrupt_source_map_pkg::PRIO_NONE;
            pendingStatus <= 32'h00000000;
        end else begin
            vector_base_reg <= next_base;
            excRequest <= next_request;
            excNumber <= next_number;
            excVector <= next_vector;
            lateArrival <= lateSwitch;
            runningPriority <= runPrio;
            pendingStatus <= next_pend[NI-1:0];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    property p_spi_map;
        (|(spiFlags0 & spiEnables0)) |=> irqLines[interrupt_source_map_pkg::IRQ_SPI0];
    endproperty
    a_spi_map: assert property (p_spi_map) else $error("serial line 0 did not follow its flags");

    property p_pin_map;
        pin_event_status[5] |=> irqLines[29] ##1 (pend[29] || !enableStatus[29] || $past(setAct[29]));
    endproperty
    a_pin_map: assert property (p_pin_map) else $error("pin channel 5 did not reach number 29");

    property p_multirate;
        (multirateFlags != 4'h0) |=> irqLines[interrupt_source_map_pkg::IRQ_MULTIRATE];
    endproperty
    a_multirate: assert property (p_multirate) else $error("multi-rate line missed a channel flag");

    property p_reserved;
        !pend[2] && pend[7:6] == 2'h0 && !pend[14] && pend[23:16] == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved number became pending");

    property p_vector_hold;
        !vectorBaseWrite |=> vector_base_reg == $past(vector_base_reg);
    endproperty
    a_vector_hold: assert property (p_vector_hold) else $error("vector base changed without a write");

    property p_vector_write;
        vectorBaseWrite |=> vector_base_reg == ($past(vectorBaseData) & interrupt_source_map_pkg::VECTOR_BASE_MASK);
    endproperty
    a_vector_write: assert property (p_vector_write) else $error("vector base write not taken");

    property p_nmi_first;
        nmiSoftware && !active[interrupt_source_map_pkg::IDX_NMI] && !excRequest |=>
            ##1 (excNumber == interrupt_source_map_pkg::EXC_NMI || $past(excAccept));
    endproperty
    a_nmi_first: assert property (p_nmi_first) else $error("non-maskable request not presented");

    property p_late;
        lateSwitch |=> lateArrival && excRequest && presentedPrio < $past(presentedPrio);
    endproperty
    a_late: assert property (p_late) else $error("late arrival did not replace the entry");

    property p_tie;
        eligible[0] && eligible[1] && extPrio[2:0] == extPrio[5:3] |-> candIdx != 6'h01;
    endproperty
    a_tie: assert property (p_tie) else $error("higher number won a priority tie");

    property p_mask;
        boostEnable && candFound && candIdx != 6'(interrupt_source_map_pkg::IDX_NMI) |->
            candPrio <= {1'b0, boostLevel};
    endproperty
    a_mask: assert property (p_mask) else $error("masked level was selected");

    property p_svc;
        svcRequest |=> pend[interrupt_source_map_pkg::IDX_SVC];
    endproperty
    a_svc: assert property (p_svc) else $error("supervisor call not pended");

    property p_commit;
        entryCommit |=> active[$past(presentedIdx)] && !excRequest;
    endproperty
    a_commit: assert property (p_commit) else $error("entry did not mark the exception active");

    property p_nmi_line;
        nmiSourceEnable && irqLines[nmiSourceIndex] |=> pend[interrupt_source_map_pkg::IDX_NMI];
    endproperty
    a_nmi_line: assert property (p_nmi_line) else $error("selected line did not pend the non-maskable request");

    c_late: cover property (lateSwitch);
    c_nmi: cover property (excRequest && excNumber == interrupt_source_map_pkg::EXC_NMI);
    c_nested: cover property (entryCommit && runFound);
    c_boost: cover property (boostEnable && candFound);
    c_nmi_line: cover property (nmiLine && !nmiSoftware);
endmodule

/* File: core_entry_model.sv */
// Behavioural model of the core's exception entry and return handshake
`timescale 1ns/1ps
module core_entry_model #(
    parameter int ENTRY = 12,
    parameter int HOLD = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic coreOn,
    input wire logic excRequest,
    output logic excAccept,
    output logic excEntryDone,
    output logic excReturn
);
    int cnt;
    int ret;
    logic inEntry;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {excAccept, excEntryDone, excReturn, inEntry} <= 4'h0;
            cnt <= 0;
            ret <= 0;
        end else begin
            {excAccept, excEntryDone, excReturn} <= 3'h0;
            // Long entry leaves room for a more urgent request to arrive late
            if (inEntry) begin
                cnt <= cnt + 1;
                if (cnt == ENTRY) begin
                    excEntryDone <= 1'b1;
                    inEntry <= 1'b0;
                    ret <= 1;
                end
            // No accept until the handler has returned, so handlers never nest
            end else if (coreOn && excRequest && !excAccept && ret == 0) begin
                excAccept <= 1'b1;
                inEntry <= 1'b1;
                cnt <= 0;
            end
            if (ret != 0) begin
                ret <= (ret == HOLD) ? 0 : ret + 1;
                excReturn <= (ret == HOLD);
            end
        end
    end
endmodule

/* File: testbench.sv */
// Self-checking bench for the interrupt source map
`timescale 1ns/1ps
module testbench;
    logic clk, reset, excAccept, excEntryDone, excReturn, excRequest, lateArrival, seenLate, coreOn;
    logic [7:0] spiFlags0, spiFlags1, usartFlags0, usartFlags1, usartFlags2, twoWireFlags, timer_event_flags;
    logic [7:0] spiEnables0, spiEnables1, usartEnables0, usartEnables1, usartEnables2, twoWireEnables, timerEventEnables;
    logic [7:0] pin_event_status;
    logic [3:0] multirateFlags;
    logic comparator_edge_flag, watchdog_warning_flag, brownoutLevelFlag, wakeup_alarm_flag, enableWrite, enableValue;
    logic prioWrite, pendSet, pendClear, svcRequest, pendSvSet, nmiSoftware, nmiSourceEnable, boostEnable, vectorBaseWrite;
    logic [4:0] enableIndex, pendIndex, nmiSourceIndex;
    logic [5:0] prioIndex, excNumber;
    logic [1:0] prioValue, boostLevel;
    logic [2:0] runningPriority;
    logic [31:0] vectorBaseData, excVector, pendingStatus, enableStatus, vector_base_reg;
    logic [71:0] srcBus;
    int failures, total_checks;
    localparam logic [31:0] BASE = 32'h00012300;
    assign {spiFlags0, spiFlags1, usartFlags0, usartFlags1, usartFlags2, twoWireFlags, timer_event_flags, multirateFlags,
        comparator_edge_flag, watchdog_warning_flag, brownoutLevelFlag, wakeup_alarm_flag, pin_event_status} = srcBus;
    interrupt_source_map dut (.clk, .reset, .spiFlags0, .spiEnables0, .spiFlags1, .spiEnables1, .usartFlags0,
        .usartEnables0, .usartFlags1, .usartEnables1, .usartFlags2, .usartEnables2, .twoWireFlags, .twoWireEnables,
        .timer_event_flags, .timerEventEnables, .multirateFlags, .comparator_edge_flag, .watchdog_warning_flag,
        .brownoutLevelFlag, .wakeup_alarm_flag, .pin_event_status, .enableWrite, .enableIndex, .enableValue, .prioWrite,
        .prioIndex, .prioValue, .pendSet, .pendClear, .pendIndex, .svcRequest, .pendSvSet, .nmiSoftware, .nmiSourceEnable,
        .nmiSourceIndex, .boostEnable, .boostLevel, .vectorBaseWrite, .vectorBaseData, .excAccept, .excEntryDone,
        .excReturn, .excRequest, .excNumber, .excVector, .lateArrival, .runningPriority, .pendingStatus, .enableStatus,
        .vector_base_reg);
    core_entry_model core (.clk, .reset, .coreOn, .excRequest, .excAccept, .excEntryDone, .excReturn);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk or posedge reset) begin
        if (reset) seenLate <= 1'b0;
        else if (lateArrival === 1'b1) seenLate <= 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic setPrio(input logic [5:0] idx, input logic [1:0] val);
        prioWrite <= 1'b1;
        prioIndex <= idx;
        prioValue <= val;
        tick(1);
        prioWrite <= 1'b0;
        tick(1);
    endtask
    task automatic pend(input logic [4:0] idx);
        pendSet <= 1'b1;
        pendIndex <= idx;
        tick(1);
        pendSet <= 1'b0;
        tick(1);
    endtask
    // Pending is sticky, so every source check ends by clearing all numbers
    task automatic srcChk(input logic [71:0] bits, input logic [31:0] exp);
        srcBus <= bits;
        tick(3);
        cmp("pendingStatus", exp, pendingStatus);
        srcBus <= '0;
        tick(2);
        pendClear <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            pendIndex <= 5'(i);
            tick(1);
        end
        pendClear <= 1'b0;
        tick(1);
    endtask
    task automatic drain();
        int q = 0;
        coreOn <= 1'b1;
        for (int i = 0; i < 400 && q < 6; i++) begin
            tick(1);
            q = (pendingStatus === 32'h0 && runningPriority === 3'h7 && excRequest === 1'b0) ? q + 1 : 0;
        end
        cmp("drained", 32'h6, q);
        coreOn <= 1'b0;
    endtask
    task automatic t_reset();
        cmp("vector_base_reg", 32'h0, vector_base_reg);
        cmp("runningPriority", 32'h7, {29'h0, runningPriority});
        enableWrite <= 1'b1;
        enableValue <= 1'b1;
        vectorBaseWrite <= 1'b1;
        vectorBaseData <= 32'h00012345;
        for (int i = 0; i < 32; i++) begin
            enableIndex <= 5'(i);
            tick(1);
            vectorBaseWrite <= 1'b0;
        end
        enableWrite <= 1'b0;
        tick(1);
        cmp("enableStatus", 32'hffffffff, enableStatus);
        cmp("vector_base_reg", BASE, vector_base_reg);
    endtask
    task automatic t_map();
        int pos[15] = '{71, 56, 52, 41, 38, 26, 21, 15, 11, 10, 9, 8, 0, 4, 7};
        logic [31:0] hit[15] = '{32'h1, 32'h2, 32'h8, 32'h10, 32'h20, 32'h100, 32'h200, 32'h400, 32'h800,
            32'h1000, 32'h2000, 32'h8000, 32'h01000000, 32'h10000000, 32'h80000000};
        for (int i = 0; i < 15; i++) srcChk(72'h1 << pos[i], hit[i]);
        spiEnables0 <= 8'h7f;
        srcChk(72'h1 << 71, 32'h0);
        spiEnables0 <= 8'hff;
        srcChk('1, 32'hff00bf3b);
    endtask
    task automatic t_arb();
        setPrio(6'd3, 2'h1);
        setPrio(6'd5, 2'h1);
        pend(5'd5);
        pend(5'd3);
        tick(3);
        cmp("excNumber", 32'h13, {26'h0, excNumber});
        cmp("excVector", BASE + 32'h4c, excVector);
        setPrio(6'd5, 2'h0);
        tick(2);
        cmp("excNumber", 32'h15, {26'h0, excNumber});
        boostEnable <= 1'b1;
        boostLevel <= 2'h1;
        tick(3);
        cmp("excRequest", 32'h1, {31'h0, excRequest});
        boostLevel <= 2'h0;
        tick(3);
        cmp("excRequest", 32'h0, {31'h0, excRequest});
        boostEnable <= 1'b0;
        nmiSoftware <= 1'b1;
        tick(1);
        nmiSoftware <= 1'b0;
        tick(3);
        cmp("excNumber", 32'h2, {26'h0, excNumber});
        drain();
        pendSvSet <= 1'b1;
        tick(1);
        pendSvSet <= 1'b0;
        tick(3);
        cmp("excNumber", 32'he, {26'h0, excNumber});
        svcRequest <= 1'b1;
        tick(1);
        svcRequest <= 1'b0;
        tick(3);
        cmp("excNumber", 32'hb, {26'h0, excNumber});
        drain();
    endtask
    task automatic t_late();
        coreOn <= 1'b1;
        pend(5'd3);
        for (int i = 0; i < 20 && excAccept !== 1'b1; i++) tick(1);
        pend(5'd5);
        tick(3);
        cmp("lateArrival", 32'h1, {31'h0, seenLate});
        cmp("excNumber", 32'h15, {26'h0, excNumber});
        drain();
        nmiSourceEnable <= 1'b1;
        nmiSourceIndex <= 5'd12;
        srcBus <= 72'h1 << 10;
        tick(1);
        srcBus <= '0;
        tick(4);
        cmp("excNumber", 32'h2, {26'h0, excNumber});
        nmiSourceEnable <= 1'b0;
        drain();
    endtask
    initial begin
        {enableWrite, enableValue, prioWrite, pendSet, pendClear, svcRequest, pendSvSet, nmiSoftware, coreOn} = '0;
        {nmiSourceEnable, boostEnable, vectorBaseWrite, enableIndex, pendIndex, nmiSourceIndex, prioIndex, prioValue} = '0;
        {boostLevel, vectorBaseData, srcBus} = '0;
        {spiEnables0, spiEnables1, usartEnables0, usartEnables1, usartEnables2, twoWireEnables, timerEventEnables} = '1;
        failures = 0;
        total_checks = 0;
        reset = 1'b1;
        tick(12);
        reset <= 1'b0;
        tick(1);
        t_reset();
        t_map();
        t_arb();
        t_late();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end
endmodule
